// ---- rtl/bms_pkg.sv ----
package bms_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ     = 250;
  localparam int unsigned BOOT_TIME_MS    = 3;
  localparam int unsigned BOOT_CYCLES     = BOOT_TIME_MS * 1000 * SYS_CLK_MHZ;
  localparam int unsigned BOOT_CNT_W      = 20;

  // ----------------------------------------------------------------
  // Strap, OTG role and debug UART positions on the general purpose pin bank
  // ----------------------------------------------------------------
  localparam int unsigned GP_W            = 32;
  localparam int unsigned STRAP_HI_POS    = 31;
  localparam int unsigned STRAP_LO_POS    = 30;
  localparam int unsigned OTG_ID_POS      = 29;
  localparam int unsigned UART_TX_POS     = 28;
  localparam int unsigned UART_RX_POS     = 27;

  // ----------------------------------------------------------------
  // Strap codes
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_PARALLEL   = 2'h0;
  localparam logic [1:0] STRAP_SERIAL     = 2'h1;
  localparam logic [1:0] STRAP_SPI        = 2'h2;
  localparam logic [1:0] STRAP_ALONE      = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  RST_MODE        = 2'h0;
  localparam logic [31:0] RST_GP_OE       = 32'h0000_0000;

  typedef enum logic [3:0] {
    BMS_ST_RESET = 4'b0001,
    BMS_ST_BOOT  = 4'b0010,
    BMS_ST_COPRO = 4'b0100,
    BMS_ST_ALONE = 4'b1000
  } bms_state_type;

  typedef struct packed {
    logic parallelHostEn;
    logic fastSerialEn;
    logic spiSlaveEn;
    logic eepromEn;
  } bms_if_en_type;

  typedef struct packed {
    logic debugUartEn;
    logic otgPortIsPeriph;
    logic otgPortIsHost;
    logic port1bPeriph;
    logic port2aPeriph;
    logic port2bPeriph;
  } bms_usb_cfg_type;

endpackage

// ---- rtl/bms_strap_latch.sv ----
`timescale 1ns/1ps
module bms_strap_latch
  import bms_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  // Pins
  input  wire logic [1:0] strapIn,
  input  wire logic       clockFrequencySelect,
  // Captured values
  output logic [1:0]      modeCode,
  output logic            refClk12,
  output logic            captured
);

  logic [1:0] modeCode_ff;
  logic       refClk12_ff;
  logic       captured_ff;

  // First clocked edge after release takes the straps, then holds
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      modeCode_ff <= RST_MODE;
      refClk12_ff <= 1'b0;
      captured_ff <= 1'b0;
    end
    else if (!captured_ff)
    begin
      modeCode_ff <= strapIn;
      refClk12_ff <= clockFrequencySelect;
      captured_ff <= 1'b1;
    end
  end

  assign modeCode = modeCode_ff;
  assign refClk12 = refClk12_ff;
  assign captured = captured_ff;

endmodule

// ---- rtl/bms_boot_timer.sv ----
`timescale 1ns/1ps
module bms_boot_timer
  import bms_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES
)
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // Control
  input  wire logic start,
  output logic      done
);

  logic [BOOT_CNT_W-1:0] cnt_ff;
  logic                  done_ff;
  wire  logic            lastTick = (cnt_ff == BOOT_CNT_W'(BOOT_LEN - 1));

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end
    else if (start && !done_ff)
    begin
      cnt_ff  <= cnt_ff + 1'b1;
      done_ff <= lastTick;
    end
  end

  assign done = done_ff;

endmodule

// ---- rtl/bms_boot_select.sv ----
`timescale 1ns/1ps
// What this block does
// - Straps on pins 31:30 are captured when reset is released.
// - Code 00 parallel, 01 fast serial, 10 SPI slave, 11 EEPROM standalone.
// - Boot procedure lasts 3 ms after reset release, plus three clock cycles.
// - Strap pins read only during boot, then free as general pins.
// - Non-standalone codes enable only the matching interface, then wait idle.
// - Coprocessor loading starts only after the 3 ms boot time.
// - Parallel port 16 bit; serial 2M baud; SPI slave 2 Mb/s limits.
// - Standalone: internal CPU is main, firmware from EEPROM or USB.
// - Standalone: both strap pins become outputs for the EEPROM bus.
// - Standalone: pins 28 and 27 become the debug UART.
// - Standalone: pin 29 is OTG role, 1 peripheral, 0 host.
// - Standalone: ports 1B, 2A, 2B peripheral; all other pins inputs.
// - Clock select pin sampled at reset; high means 12 MHz reference.
module bms_boot_select
  import bms_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES
)
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            resetn,
  // Pins
  input  wire logic [GP_W-1:0] gpIn,
  input  wire logic            clockFrequencySelect,
  // Internal EEPROM bus master and debug UART drive
  input  wire logic            eepromClkOut,
  input  wire logic            eepromDataOut,
  input  wire logic            uartTxOut,
  // Pin drive
  output logic [GP_W-1:0]      gpOut,
  output logic [GP_W-1:0]      gpOe,
  // Status
  output logic [1:0]           bootMode,
  output logic                 refClk12,
  output logic                 bootBusy,
  output logic                 loadAllowed,
  output logic                 internalCpuMain,
  output bms_if_en_type        ifEnable,
  output bms_usb_cfg_type      usbCfg,
  output logic                 uartRxIn
);

  // ----------------------------------------------------------------
  // Capture and boot timing
  // ----------------------------------------------------------------
  logic [1:0] modeCode;
  logic       refSel;
  logic       captured;
  logic       bootDone;

  bms_strap_latch u_latch (
    .sys_clk              (sys_clk),
    .resetn               (resetn),
    .strapIn              (gpIn[STRAP_HI_POS:STRAP_LO_POS]),
    .clockFrequencySelect (clockFrequencySelect),
    .modeCode             (modeCode),
    .refClk12             (refSel),
    .captured             (captured)
  );

  // restores this timer with every reset pulse
  bms_boot_timer #(.BOOT_LEN(BOOT_LEN)) u_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (captured),
    .done    (bootDone)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  bms_state_type state_ff;
  bms_state_type nxt_state;

  wire logic isAlone = (modeCode == STRAP_ALONE);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      BMS_ST_RESET: if (captured) nxt_state = BMS_ST_BOOT;
      BMS_ST_BOOT:  if (bootDone) nxt_state = isAlone ? BMS_ST_ALONE : BMS_ST_COPRO;
      BMS_ST_COPRO: nxt_state = BMS_ST_COPRO;
      BMS_ST_ALONE: nxt_state = BMS_ST_ALONE;
      default:      nxt_state = BMS_ST_RESET;
    endcase
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state_ff <= BMS_ST_RESET;
    else
      state_ff <= nxt_state;
  end

  wire logic inCopro = (state_ff == BMS_ST_COPRO);
  wire logic inAlone = (state_ff == BMS_ST_ALONE);

  // ----------------------------------------------------------------
  // Interface enables and USB role
  // ----------------------------------------------------------------
  // Only one coprocessor link is ever live; rate limits live in each port
  bms_if_en_type nxt_ifEnable;
  assign nxt_ifEnable.parallelHostEn = inCopro && (modeCode == STRAP_PARALLEL);
  assign nxt_ifEnable.fastSerialEn   = inCopro && (modeCode == STRAP_SERIAL);
  assign nxt_ifEnable.spiSlaveEn     = inCopro && (modeCode == STRAP_SPI);
  assign nxt_ifEnable.eepromEn       = inAlone;

  // Pin 29 is live, so the role follows it after boot
  wire logic otg_role_identifier = gpIn[OTG_ID_POS];
  bms_usb_cfg_type nxt_usbCfg;
  assign nxt_usbCfg.debugUartEn     = inAlone;
  assign nxt_usbCfg.otgPortIsPeriph = inAlone && otg_role_identifier;
  assign nxt_usbCfg.otgPortIsHost   = inAlone && !otg_role_identifier;
  assign nxt_usbCfg.port1bPeriph    = inAlone;
  assign nxt_usbCfg.port2aPeriph    = inAlone;
  assign nxt_usbCfg.port2bPeriph    = inAlone;

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic [GP_W-1:0] nxt_gpOe;
  logic [GP_W-1:0] nxt_gpOut;

  always_comb
  begin
    nxt_gpOe  = RST_GP_OE;
    nxt_gpOut = '0;
    if (inAlone)
    begin
      nxt_gpOe[STRAP_HI_POS]  = 1'b1;
      nxt_gpOe[STRAP_LO_POS]  = 1'b1;
      nxt_gpOut[STRAP_HI_POS] = eepromClkOut;
      nxt_gpOut[STRAP_LO_POS] = eepromDataOut;
      nxt_gpOe[UART_TX_POS]   = 1'b1;
      nxt_gpOut[UART_TX_POS]  = uartTxOut;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  bms_if_en_type   ifEnable_ff;
  bms_usb_cfg_type usbCfg_ff;
  logic [GP_W-1:0] gpOut_ff;
  logic [GP_W-1:0] gpOe_ff;
  logic [1:0]      bootMode_ff;
  logic            refClk12_ff;
  logic            bootBusy_ff;
  logic            loadAllowed_ff;
  logic            cpuMain_ff;
  logic            uartRx_ff;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ifEnable_ff    <= '0;
      usbCfg_ff      <= '0;
      gpOut_ff       <= '0;
      gpOe_ff        <= RST_GP_OE;
      bootMode_ff    <= RST_MODE;
      refClk12_ff    <= 1'b0;
      bootBusy_ff    <= 1'b1;
      loadAllowed_ff <= 1'b0;
      cpuMain_ff     <= 1'b0;
      uartRx_ff      <= 1'b0;
    end
    else
    begin
      ifEnable_ff    <= nxt_ifEnable;
      usbCfg_ff      <= nxt_usbCfg;
      gpOut_ff       <= nxt_gpOut;
      gpOe_ff        <= nxt_gpOe;
      bootMode_ff    <= modeCode;
      refClk12_ff    <= refSel;
      bootBusy_ff    <= !(inCopro || inAlone);
      loadAllowed_ff <= inCopro;
      cpuMain_ff     <= inAlone;
      uartRx_ff      <= inAlone && gpIn[UART_RX_POS];
    end
  end

  assign ifEnable        = ifEnable_ff;
  assign usbCfg          = usbCfg_ff;
  assign gpOut           = gpOut_ff;
  assign gpOe            = gpOe_ff;
  assign bootMode        = bootMode_ff;
  assign refClk12        = refClk12_ff;
  assign bootBusy        = bootBusy_ff;
  assign loadAllowed     = loadAllowed_ff;
  assign internalCpuMain = cpuMain_ff;
  assign uartRxIn        = uartRx_ff;

endmodule

// ---- sim/bms_boot_select_assertions.sv ----
`timescale 1ns/1ps
module bms_boot_select_assertions
  import bms_pkg::*;
#(
  parameter int unsigned BOOT_LEN = BOOT_CYCLES
)
(
  // Watched ports
  input wire logic            sys_clk,
  input wire logic            resetn,
  input wire logic [GP_W-1:0] gpIn,
  input wire logic            eepromClkOut,
  input wire logic            eepromDataOut,
  input wire logic            uartTxOut,
  input wire logic [GP_W-1:0] gpOut,
  input wire logic [GP_W-1:0] gpOe,
  input wire logic [1:0]      bootMode,
  input wire logic            refClk12,
  input wire logic            bootBusy,
  input wire logic            loadAllowed,
  input wire logic            internalCpuMain,
  input wire bms_if_en_type   ifEnable,
  input wire bms_usb_cfg_type usbCfg,
  input wire logic            uartRxIn
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic        alone;
  logic        copro;
  int unsigned busyCnt_ff;
  assign alone = !bootBusy && bootMode == STRAP_ALONE;
  assign copro = !bootBusy && bootMode != STRAP_ALONE;
  // Holds after boot so the load check sees the full window
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      busyCnt_ff <= 0;
    else if (bootBusy)
      busyCnt_ff <= busyCnt_ff + 1;
  a_boot_bound: assert property (bootBusy |-> busyCnt_ff <= BOOT_LEN + 4)
    else $error("boot window too long");
  a_load_late: assert property ($rose(loadAllowed) |-> busyCnt_ff >= BOOT_LEN)
    else $error("load allowed too early");
  a_mode_held: assert property (!bootBusy |-> $stable(bootMode) && $stable(refClk12))
    else $error("latched choice moved");
  a_boot_quiet: assert property (bootBusy |-> gpOe == '0 && !loadAllowed)
    else $error("pin driven during boot");
  a_copro_only: assert property (copro |-> ifEnable == (4'b1000 >> bootMode)
    && loadAllowed && gpOe == '0 && !internalCpuMain) else $error("wrong coprocessor set");
  a_alone_pins: assert property (alone |-> gpOe == 32'hD000_0000 && ifEnable == 4'b0001
    && internalCpuMain && !loadAllowed) else $error("wrong standalone pins");
  a_alone_drive: assert property (alone && $past(alone) |->
    gpOut[31] == $past(eepromClkOut) && gpOut[30] == $past(eepromDataOut)
    && gpOut[28] == $past(uartTxOut)) else $error("standalone drive wrong");
  a_otg_role: assert property (alone && $past(alone) |->
    uartRxIn == $past(gpIn[27])
    && usbCfg == {1'b1, $past(gpIn[29]), !$past(gpIn[29]), 3'b111})
    else $error("otg role or rx wrong");
endmodule

bind bms_boot_select bms_boot_select_assertions #(.BOOT_LEN(BOOT_LEN)) u_chk (.*);

// ---- sim/bms_far_end.sv ----
`timescale 1ns/1ps
module bms_far_end
  import bms_pkg::*;
(
  // Pin bank
  input  wire logic            sys_clk,
  input  wire logic [GP_W-1:0] gpOut,
  input  wire logic [GP_W-1:0] gpOe,
  // Board levels
  input  wire logic [1:0]      strapPull,
  input  wire logic            otg_role_identifier,
  input  wire logic            rxLine,
  output logic [GP_W-1:0]      gpIn
);
  // -----------
  // Board wires
  // -----------
  logic [GP_W-1:0] float_ff;
  logic [GP_W-1:0] board;
  initial float_ff = 32'h0000_0000;
  // Unpulled pins toggle, so a stale level never passes for a drive
  always @(posedge sys_clk)
    float_ff <= ~float_ff;
  assign board = {strapPull, otg_role_identifier, float_ff[28], rxLine, float_ff[26:0]};
  // Strap resistors double as the EEPROM pull-ups
  assign gpIn = (gpOe & gpOut) | (~gpOe & board);
endmodule

// ---- sim/bms_boot_select_tb.sv ----
`timescale 1ns/1ps
module bms_boot_select_tb;
  import bms_pkg::*;
  localparam int unsigned BLEN = 20;
  // Sixteen reference periods at this clock, rounded up
  localparam int unsigned RST_HOLD = 334;
  logic sys_clk = 0, resetn = 0, clockFrequencySelect = 0, otg_role_identifier = 0, rxLine = 0;
  logic eepromClkOut = 0, eepromDataOut = 0, uartTxOut = 0;
  logic [1:0] strapPull = 0;
  logic [4:0] rv;
  logic [GP_W-1:0] gpIn, gpOut, gpOe;
  logic [1:0] bootMode;
  logic refClk12, bootBusy, loadAllowed, internalCpuMain, uartRxIn;
  bms_if_en_type ifEnable;
  bms_usb_cfg_type usbCfg;
  int n_fail = 0, n_compared = 0, seed = 65656, n, k;
  int expQ[$];
  // ---------------
  // Build and tasks
  // ---------------
  bms_boot_select #(.BOOT_LEN(BLEN)) dut (.*);
  bms_far_end far (.*);
  always #2 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic boot(input int c, input logic s);
    @(posedge sys_clk);
    resetn <= 0;
    strapPull <= c[1:0];
    clockFrequencySelect <= s;
    expQ.push_back(c);
    repeat (RST_HOLD - 1) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({bootBusy, loadAllowed, internalCpuMain}, 3'b100);
    chk({ifEnable, usbCfg}, 0);
    chk(gpOe | gpOut, 0);
    @(posedge sys_clk);
    resetn <= 1;
    @(posedge sys_clk);
    strapPull <= ~c[1:0];
    clockFrequencySelect <= ~s;
    @(negedge sys_clk);
    chk(gpOe, 0);
    n = 1;
    while (bootBusy !== 0 && n < 100)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk(n >= BLEN + 1 && n <= BLEN + 3, 1);
    chk(bootMode, expQ.pop_front());
    chk(refClk12, s);
    chk(loadAllowed, c != 3);
    chk(internalCpuMain, c == 3);
    chk(ifEnable, c == 3 ? 1 : 8 >> c);
    chk(gpOe, c == 3 ? 32'hD000_0000 : 0);
    repeat (6)
    begin
      rv = 5'($random(seed));
      @(posedge sys_clk);
      {eepromClkOut, eepromDataOut, uartTxOut, otg_role_identifier, rxLine} <= rv;
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk(uartRxIn, c == 3 ? rv[0] : 0);
      chk(gpOut, c == 3 ? {rv[4:3], 1'b0, rv[2], 28'h000_0000} : 0);
      chk(usbCfg, c == 3 ? {1'b1, rv[1], ~rv[1], 3'b111} : 0);
    end
  endtask
  // ---------
  // Sequence
  // ---------
  initial
  begin
    repeat (3) @(posedge sys_clk);
    for (k = 0; k < 12; k++)
      boot(k < 8 ? k % 4 : $random(seed) & 3, k < 8 ? k[2] : 1'($random(seed)));
    wrap_up();
  end
  initial
  begin
    #(12 * (RST_HOLD + 200) * 4);
    n_fail++;
    wrap_up();
  end
endmodule
